// >>> card_host_port_dma_request_test.sv
// Purpose: Host and card ends joined, driven from both user sides
// Assumes: 10 MHz core_clk, synchronous active-high reset
// Notes: Each scenario resets first so direction changes never race a request
`timescale 1ns/1ps
module card_host_port_dma_request_test;
   logic core_clk, rst, cfg_strap_ground, req_valid, req_ready, req_write, req_ctrl;
   chp_pkg::chp_mode_type cfg_mode;
   logic [2:0] req_addr;
   logic [15:0] req_wdata, resp_data, dma_wr_data, dma_rd_data, tx_data, rx_data, wr_seen, rd;
   logic resp_valid, dma_enable, dma_dir_to_host, dma_wr_valid, dma_wr_ready, dma_rd_valid;
   logic dma_rd_ready, tx_valid, tx_ready, rx_valid, rx_ready, dma_to_host, cmd_valid;
   logic is_slave, selected, inack_seen;
   logic [7:0] cmd_code, last_cmd;
   int num_errors, samples_checked, cycles, cmd_count;

   chp_if port_bus();
   chp_host i_chp_host (.core_clk, .rst, .port(port_bus), .cfg_mode, .cfg_strap_ground,
      .req_valid, .req_ready, .req_write, .req_ctrl, .req_addr, .req_wdata, .resp_valid,
      .resp_data, .dma_enable, .dma_dir_to_host, .dma_wr_data, .dma_wr_valid, .dma_wr_ready,
      .dma_rd_data, .dma_rd_valid, .dma_rd_ready);
   chp_device i_chp_device (.core_clk, .rst, .port(port_bus), .tx_data, .tx_valid, .tx_ready,
      .rx_data, .rx_valid, .rx_ready, .dma_to_host, .cmd_valid, .cmd_code, .is_slave,
      .selected);
   chp_monitor i_chp_monitor (.core_clk, .rst, .port_mode(port_bus.port_mode),
      .addr(port_bus.addr), .card_enable_n(port_bus.card_enable_n),
      .task_file_select_n(port_bus.task_file_select_n),
      .control_block_select_n(port_bus.control_block_select_n),
      .io_read_strobe_n(port_bus.io_read_strobe_n),
      .io_write_strobe_n(port_bus.io_write_strobe_n),
      .dma_acknowledge_n(port_bus.dma_acknowledge_n), .dev_d(port_bus.dev_d),
      .dev_d_oe(port_bus.dev_d_oe), .input_acknowledge_n(port_bus.input_acknowledge_n),
      .dma_request(port_bus.dma_request));

   // ==========================================================
   // Clock, watchers and timeout
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cmd_valid === 1'b1) begin
         cmd_count <= cmd_count + 1;
         last_cmd <= cmd_code;
      end
      if (rst) inack_seen <= 1'b0;
      else if (port_bus.input_acknowledge_n === 1'b0) inack_seen <= 1'b1;
      if (port_bus.io_write_strobe_n === 1'b0) wr_seen <= port_bus.d;
      // Whole run needs a few hundred cycles
      if (cycles == 20000) begin
         num_errors++;
         final_report();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("Checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic reset_dut(input chp_pkg::chp_mode_type m, input logic gnd, input logic out);
      @(posedge core_clk);
      cfg_mode <= m;
      cfg_strap_ground <= gnd;
      dma_to_host <= out;
      dma_dir_to_host <= out;
      dma_enable <= 1'b0;
      rx_ready <= 1'b0;
      dma_rd_ready <= 1'b0;
      rst <= 1'b1;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
   endtask

   task automatic wait_high(ref logic sig);
      int n;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (sig !== 1'b1 && n < 200);
      if (n >= 200) check(16'h0001, 16'h0000);
   endtask

   task automatic reg_cycle(input logic wr, input logic [2:0] a, input logic [15:0] wd);
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= wd;
      wait_high(req_ready);
      @(posedge core_clk);
      req_valid <= 1'b0;
      wait_high(resp_valid);
      rd = resp_data;
   endtask

   task automatic push_word(input logic host_side, input logic [15:0] w);
      @(posedge core_clk);
      if (host_side) begin
         dma_wr_valid <= 1'b1;
         dma_wr_data <= w;
         wait_high(dma_wr_ready);
      end else begin
         tx_valid <= 1'b1;
         tx_data <= w;
         wait_high(tx_ready);
      end
      @(posedge core_clk);
      dma_wr_valid <= 1'b0;
      tx_valid <= 1'b0;
   endtask

   task automatic collect(input logic from_rx, input logic [15:0] e0, input logic [15:0] e1);
      for (int i = 0; i < 2; i++) begin
         if (from_rx) wait_high(rx_valid);
         else wait_high(dma_rd_valid);
         check(from_rx ? rx_data : dma_rd_data, i == 0 ? e0 : e1);
         @(posedge core_clk);
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic s_regs();
      reset_dut(chp_pkg::CHP_MODE_DISK, 1'b1, 1'b1);
      check({15'h0, is_slave}, 16'h0000);
      cfg_strap_ground <= 1'b0;
      reg_cycle(1'b1, chp_pkg::TF_DRIVE, 16'h00A0);
      check({15'h0, is_slave}, 16'h0000);
      reg_cycle(1'b1, chp_pkg::TF_COMMAND, 16'h005A);
      // Command pulse follows the trailing edge, after the host answer
      repeat (3) @(negedge core_clk);
      check(16'(cmd_count), 16'h0001);
      check({8'h00, last_cmd}, 16'h005A);
      reg_cycle(1'b0, chp_pkg::TF_DRIVE, 16'h0000);
      check(rd, 16'h00A0);
      // Drive bit picks the other unit, so this one must float its request
      reg_cycle(1'b1, chp_pkg::TF_DRIVE, 16'h00B0);
      push_word(1'b0, 16'h7E81);
      repeat (10) @(posedge core_clk);
      check({15'h0, port_bus.dma_request_oe}, 16'h0000);
      check({15'h0, selected}, 16'h0000);
   endtask

   task automatic s_strap_open();
      reset_dut(chp_pkg::CHP_MODE_DISK, 1'b0, 1'b1);
      check({15'h0, is_slave}, 16'h0001);
      reg_cycle(1'b1, chp_pkg::TF_DRIVE, 16'h0010);
      push_word(1'b0, 16'h3C3C);
      repeat (4) @(posedge core_clk);
      check({15'h0, port_bus.dma_request}, 16'h0001);
      check({15'h0, selected}, 16'h0001);
   endtask

   task automatic s_dma_out();
      reset_dut(chp_pkg::CHP_MODE_DISK, 1'b1, 1'b1);
      push_word(1'b0, 16'hC3A5);
      push_word(1'b0, 16'h1E96);
      @(negedge core_clk);
      check({15'h0, tx_ready}, 16'h0000);
      check({15'h0, port_bus.dma_request}, 16'h0001);
      @(posedge core_clk);
      dma_enable <= 1'b1;
      // Host read side stalls while both words cross
      repeat (40) @(posedge core_clk);
      dma_rd_ready <= 1'b1;
      collect(1'b0, 16'hC3A5, 16'h1E96);
   endtask

   task automatic s_dma_in();
      reset_dut(chp_pkg::CHP_MODE_DISK, 1'b1, 1'b0);
      dma_enable <= 1'b1;
      push_word(1'b1, 16'h8001);
      push_word(1'b1, 16'hF00F);
      repeat (10) @(posedge core_clk);
      check(wr_seen, 16'hF00F);
      check({15'h0, port_bus.dma_request}, 16'h0000);
      rx_ready <= 1'b1;
      collect(1'b1, 16'h8001, 16'hF00F);
   endtask

   task automatic s_card_modes();
      reset_dut(chp_pkg::CHP_MODE_IO, 1'b0, 1'b0);
      check({15'h0, port_bus.master_slave_strap}, 16'h0000);
      reg_cycle(1'b1, chp_pkg::TF_DATA, 16'hA55A);
      check(wr_seen, 16'hA55A);
      reg_cycle(1'b1, 3'h1, 16'h5533);
      reg_cycle(1'b0, 3'h1, 16'h0000);
      check(rd, 16'h0033);
      check({15'h0, inack_seen}, 16'h0001);
      reset_dut(chp_pkg::CHP_MODE_MEMORY, 1'b0, 1'b0);
      reg_cycle(1'b0, 3'h1, 16'h0000);
      check(rd, chp_pkg::FLOAT_WORD);
      check({15'h0, inack_seen}, 16'h0000);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      cfg_mode = chp_pkg::CHP_MODE_DISK;
      {cfg_strap_ground, req_valid, req_write, req_ctrl, dma_enable} = 5'h00;
      {dma_dir_to_host, dma_wr_valid, dma_rd_ready, tx_valid, rx_ready, dma_to_host} = 6'h00;
      {req_addr, req_wdata, dma_wr_data, tx_data} = 51'h0;
      {num_errors, samples_checked, cycles, cmd_count} = 128'h0;
      s_regs();
      s_strap_open();
      s_dma_out();
      s_dma_in();
      s_card_modes();
      final_report();
   end
endmodule

// >>> chp_device.sv
// Purpose: Card end of the parallel host port with DMA request handshake
// Assumes: Pin inputs synchronous to core_clk; host honours strobe timing
// Notes: Two-entry buffers in each data direction absorb user stalls
//        Task file writes land in both units; only the selected one answers
// Functional notes
// - Disk mode: grounded strap master, open slave
// - Card modes: host grounds strap or uses A25
// - Card modes: bit0 even byte, bit8 odd; odd-address registers here still use bits 7:0
// - Disk mode: registers on low byte, data 16-bit
// - I/O mode: acknowledge while answering selected read
// - Memory mode: input acknowledge unused
// - Disk mode: request when ready to move data
// - Host direction: read strobe out, write in
// - Request held until acknowledge, then re-raised
// - Request undriven unless this device selected
// - Selects negated, 16-bit words during acknowledge
`timescale 1ns/1ps
module chp_device (
   input wire logic core_clk,
   input wire logic rst,
   chp_if.device_end port,
   input wire logic [15:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [15:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   input wire logic dma_to_host,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic is_slave,
   output logic selected
);
   // ==========================================================
   // State
   typedef struct packed {
      logic is_slave;
      logic dev_bit;
      logic [7:0][7:0] regs;
      logic rd_prev;
      logic wr_prev;
      logic [15:0] wr_word;
      logic dma_request;
      chp_pkg::chp_fifo_type tx;
      chp_pkg::chp_fifo_type rx;
      logic cmd_valid;
      logic [7:0] cmd_code;
      logic [15:0] d_out;
      logic d_oe;
      logic in_ack_n;
      logic in_ack_oe;
   } chp_dev_state_type;

   chp_dev_state_type r;
   chp_dev_state_type next_r;

   // ==========================================================
   // Buffer level helpers
   function automatic logic buf_not_empty(chp_pkg::chp_fifo_type f);
      return (f.cnt != 2'h0);
   endfunction

   function automatic logic buf_has_room(chp_pkg::chp_fifo_type f);
      return (f.cnt < chp_pkg::BUF_DEPTH);
   endfunction

   // ==========================================================
   // Decode
   logic disk;
   logic io_mode;
   logic rd_act;
   logic wr_act;
   logic rd_end;
   logic wr_end;
   logic sel_me;
   logic dma_cycle;
   logic reg_sel;
   logic data_access;
   logic word_access;
   logic dma_ready;
   logic tx_push;
   logic tx_pop;
   logic rx_push;
   logic rx_pop;

   always_comb begin
      disk = (port.port_mode == chp_pkg::CHP_MODE_DISK);
      io_mode = (port.port_mode == chp_pkg::CHP_MODE_IO);
      rd_act = !port.io_read_strobe_n;
      wr_act = !port.io_write_strobe_n;
      // Writes take effect on the trailing edge of the strobe
      rd_end = r.rd_prev && !rd_act;
      wr_end = r.wr_prev && !wr_act;
      // Card modes have no second unit to defer to
      sel_me = !disk || (r.is_slave == r.dev_bit);
      dma_cycle = disk && !port.dma_acknowledge_n;
      reg_sel = disk ? (!port.task_file_select_n && port.dma_acknowledge_n)
                     : (io_mode && !port.card_enable_n);
      data_access = reg_sel && (port.addr == chp_pkg::TF_DATA);
      word_access = dma_cycle || data_access;
      // ready means data waiting or room for it
      dma_ready = dma_to_host ? buf_not_empty(r.tx) : buf_has_room(r.rx);
      // Ready is combinational so a full buffer stalls the user at once
      tx_ready = buf_has_room(r.tx);
      tx_push = tx_valid && tx_ready;
      tx_pop = rd_end && word_access && sel_me && buf_not_empty(r.tx);
      rx_push = wr_end && word_access && sel_me;
      rx_pop = rx_ready && buf_not_empty(r.rx);
   end

   // ==========================================================
   // Next state
   always_comb begin
      next_r = r;
      next_r.rd_prev = rd_act;
      next_r.wr_prev = wr_act;
      next_r.cmd_valid = 1'b0;
      // Bus word caught while the strobe is low, used at its trailing edge
      if (wr_act) begin
         next_r.wr_word = port.d;
      end
      next_r.tx = chp_pkg::chp_fifo_step(r.tx, tx_push, tx_pop, tx_data);
      // A full buffer drops a host word; the request keeps the host from overrunning it
      next_r.rx = chp_pkg::chp_fifo_step(r.rx, rx_push, rx_pop, r.wr_word);

      // Task file byte writes
      if (wr_end && reg_sel && !data_access) begin
         next_r.regs[port.addr] = r.wr_word[7:0];
         if (port.addr == chp_pkg::TF_DRIVE) begin
            next_r.dev_bit = r.wr_word[chp_pkg::DRIVE_DEV_BIT];
         end
         // Command pulse only from the selected unit
         if (port.addr == chp_pkg::TF_COMMAND && sel_me) begin
            next_r.cmd_valid = 1'b1;
            next_r.cmd_code = r.wr_word[7:0];
         end
      end

      // Read data drive
      // Data and enable registered together, so the bus never glitches
      next_r.d_oe = rd_act && sel_me && (reg_sel || dma_cycle);
      if (word_access) begin
         next_r.d_out = r.tx.mem[0];
      end else begin
         next_r.d_out = {chp_pkg::BYTE_ZERO, r.regs[port.addr]};
      end

      // acknowledge while answering read
      // Driven high in I/O mode so the host never reads a floating line
      next_r.in_ack_oe = io_mode;
      next_r.in_ack_n = !(io_mode && reg_sel && rd_act);
      if (port.port_mode == chp_pkg::CHP_MODE_MEMORY) begin
         next_r.in_ack_oe = 1'b0;
         next_r.in_ack_n = 1'b1;
      end

      // hold until acknowledge, drop after its word
      if (!r.dma_request) begin
         if (disk && sel_me && port.dma_acknowledge_n && dma_ready) begin
            next_r.dma_request = 1'b1;
         end
      end else if (!port.dma_acknowledge_n && (rd_end || wr_end)) begin
         next_r.dma_request = 1'b0;
      // Host copies cfg_mode every cycle, so mode can move outside reset; this drops the request
      end else if (!disk) begin
         next_r.dma_request = 1'b0;
      end

      if (rst) begin
         next_r = '0;
         // open strap reads high, slave
         // Strap must settle before reset is released
         next_r.is_slave = port.master_slave_strap;
         next_r.in_ack_n = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      r <= next_r;
   end

   // ==========================================================
   // Outputs
   assign port.dev_d = r.d_out;
   assign port.dev_d_oe = r.d_oe;
   assign port.input_acknowledge_n_o = r.in_ack_n;
   assign port.input_acknowledge_oe = r.in_ack_oe;
   assign port.dma_request_o = r.dma_request;
   assign port.dma_request_oe = disk && sel_me;
   assign rx_data = r.rx.mem[0];
   assign rx_valid = (r.rx.cnt != 2'h0);
   assign cmd_valid = r.cmd_valid;
   assign cmd_code = r.cmd_code;
   assign is_slave = r.is_slave;
   assign selected = sel_me;
endmodule

// >>> chp_host.sv
// Purpose: Host controller end of the parallel card port
// Assumes: One request at a time; DMA served between register cycles
// Notes: Read words from DMA pass a two-entry buffer to the user
`timescale 1ns/1ps
module chp_host (
   input wire logic core_clk,
   input wire logic rst,
   chp_if.host_end port,
   input wire chp_pkg::chp_mode_type cfg_mode,
   input wire logic cfg_strap_ground,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic req_ctrl,
   input wire logic [2:0] req_addr,
   input wire logic [15:0] req_wdata,
   output logic resp_valid,
   output logic [15:0] resp_data,
   input wire logic dma_enable,
   input wire logic dma_dir_to_host,
   input wire logic [15:0] dma_wr_data,
   input wire logic dma_wr_valid,
   output logic dma_wr_ready,
   output logic [15:0] dma_rd_data,
   output logic dma_rd_valid,
   input wire logic dma_rd_ready
);
   typedef struct packed {
      chp_pkg::chp_host_state_type state;
      chp_pkg::chp_mode_type mode;
      logic [3:0] cnt;
      logic is_dma;
      logic write;
      logic ctrl;
      logic [2:0] addr;
      logic [15:0] d_out;
      logic d_oe;
      logic ack_n;
      logic sel_n;
      logic rd_n;
      logic wr_n;
      logic resp_valid;
      logic [15:0] resp_data;
      chp_pkg::chp_fifo_type rbuf;
   } chp_host_reg_type;

   chp_host_reg_type r;
   chp_host_reg_type next_r;
   logic idle;
   logic dma_go;
   logic rd_push;
   logic rd_pop;
   logic [15:0] sample;

   always_comb begin
      idle = (r.state == chp_pkg::CHP_H_IDLE);
      dma_go = idle && dma_enable && port.dma_request && (r.mode == chp_pkg::CHP_MODE_DISK)
               && (dma_dir_to_host ? (r.rbuf.cnt < chp_pkg::BUF_DEPTH) : dma_wr_valid);
      req_ready = idle && !dma_go;
      dma_wr_ready = dma_go && !dma_dir_to_host;
      // I/O mode read is valid only with the card's acknowledge
      sample = (r.mode == chp_pkg::CHP_MODE_IO && port.input_acknowledge_n) ?
               chp_pkg::FLOAT_WORD : port.d;
      rd_push = (r.state == chp_pkg::CHP_H_STROBE) && (r.cnt == chp_pkg::STROBE_LAST)
                && r.is_dma && !r.write;
      rd_pop = dma_rd_ready && (r.rbuf.cnt != 2'h0);
   end

   // ==========================================================
   // Cycle sequencer
   always_comb begin
      next_r = r;
      next_r.mode = cfg_mode;
      next_r.resp_valid = 1'b0;
      next_r.rbuf = chp_pkg::chp_fifo_step(r.rbuf, rd_push, rd_pop, port.d);
      case (r.state)
         chp_pkg::CHP_H_IDLE: begin
            next_r.cnt = 4'h0;
            if (dma_go) begin
               next_r.is_dma = 1'b1;
               next_r.write = !dma_dir_to_host;
               next_r.d_out = dma_wr_data;
               next_r.d_oe = !dma_dir_to_host;
               next_r.ack_n = 1'b0;
               next_r.sel_n = 1'b1;
               next_r.state = chp_pkg::CHP_H_SETUP;
            end else if (req_valid) begin
               next_r.is_dma = 1'b0;
               next_r.write = req_write;
               next_r.ctrl = req_ctrl;
               next_r.addr = req_addr;
               next_r.d_out = req_wdata;
               next_r.d_oe = req_write;
               next_r.sel_n = 1'b0;
               next_r.state = chp_pkg::CHP_H_SETUP;
            end
         end
         chp_pkg::CHP_H_SETUP: begin
            next_r.rd_n = r.write;
            next_r.wr_n = !r.write;
            next_r.state = chp_pkg::CHP_H_STROBE;
         end
         chp_pkg::CHP_H_STROBE: begin
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == chp_pkg::STROBE_LAST) begin
               next_r.rd_n = 1'b1;
               next_r.wr_n = 1'b1;
               next_r.cnt = 4'h0;
               next_r.state = chp_pkg::CHP_H_RECOVER;
               if (!r.is_dma) begin
                  next_r.resp_valid = 1'b1;
                  next_r.resp_data = r.write ? r.d_out : sample;
               end
            end
         end
         chp_pkg::CHP_H_RECOVER: begin
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == chp_pkg::RECOVER_LAST) begin
               next_r.d_oe = 1'b0;
               next_r.sel_n = 1'b1;
               next_r.ack_n = 1'b1;
               next_r.cnt = 4'h0;
               next_r.state = chp_pkg::CHP_H_IDLE;
            end
         end
         default: begin
            next_r.state = chp_pkg::CHP_H_IDLE;
         end
      endcase
      if (rst) begin
         next_r = '0;
         next_r.state = chp_pkg::CHP_H_IDLE;
         next_r.mode = cfg_mode;
         next_r.ack_n = 1'b1;
         next_r.sel_n = 1'b1;
         next_r.rd_n = 1'b1;
         next_r.wr_n = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      r <= next_r;
   end

   // ==========================================================
   // Pins
   assign port.port_mode = r.mode;
   assign port.addr = r.addr;
   assign port.card_enable_n = (r.mode == chp_pkg::CHP_MODE_DISK) ? 1'b1 : r.sel_n;
   assign port.task_file_select_n = (r.mode != chp_pkg::CHP_MODE_DISK) || r.sel_n || r.ctrl;
   assign port.control_block_select_n = (r.mode != chp_pkg::CHP_MODE_DISK) || r.sel_n
                                        || !r.ctrl;
   assign port.io_read_strobe_n = r.rd_n;
   assign port.io_write_strobe_n = r.wr_n;
   assign port.dma_acknowledge_n = r.ack_n;
   assign port.strap_oe = (r.mode != chp_pkg::CHP_MODE_DISK) || cfg_strap_ground;
   assign port.host_d = r.d_out;
   assign port.host_d_oe = r.d_oe;
   assign resp_valid = r.resp_valid;
   assign resp_data = r.resp_data;
   assign dma_rd_data = r.rbuf.mem[0];
   assign dma_rd_valid = (r.rbuf.cnt != 2'h0);
endmodule

// >>> chp_if.sv
// Purpose: Pin bundle between host controller and card
// Assumes: Undriven lines read as pulled levels, data high, request low
// Notes: Every two-way line is split into value and enable per end
`timescale 1ns/1ps
interface chp_if;
   chp_pkg::chp_mode_type port_mode;
   logic [2:0] addr;
   logic card_enable_n;
   logic task_file_select_n;
   logic control_block_select_n;
   logic io_read_strobe_n;
   logic io_write_strobe_n;
   logic dma_acknowledge_n;
   logic strap_oe;
   logic master_slave_strap;
   logic [15:0] host_d;
   logic host_d_oe;
   logic [15:0] dev_d;
   logic dev_d_oe;
   logic [15:0] d;
   logic input_acknowledge_n_o;
   logic input_acknowledge_oe;
   logic input_acknowledge_n;
   logic dma_request_o;
   logic dma_request_oe;
   logic dma_request;

   // ==========================================================
   // Wire resolution
   // Strap pin: internal pull-up, host may only ground it
   assign master_slave_strap = strap_oe ? 1'b0 : 1'b1;
   assign d = dev_d_oe ? dev_d : (host_d_oe ? host_d : chp_pkg::FLOAT_WORD);
   assign input_acknowledge_n = input_acknowledge_oe ? input_acknowledge_n_o : 1'b1;
   assign dma_request = dma_request_oe ? dma_request_o : 1'b0;

   modport device_end (
      input port_mode, addr, card_enable_n, task_file_select_n, control_block_select_n,
      input io_read_strobe_n, io_write_strobe_n, dma_acknowledge_n, master_slave_strap, d,
      output dev_d, dev_d_oe, input_acknowledge_n_o, input_acknowledge_oe,
      output dma_request_o, dma_request_oe
   );

   modport host_end (
      output port_mode, addr, card_enable_n, task_file_select_n, control_block_select_n,
      output io_read_strobe_n, io_write_strobe_n, dma_acknowledge_n, strap_oe,
      output host_d, host_d_oe,
      input d, input_acknowledge_n, dma_request
   );
endinterface

// >>> chp_monitor.sv
// Purpose: Pin protocol watch for the card host port
// Assumes: All pins sampled on core_clk, reset high and synchronous
// Notes: Sees only the interface lines, never the user sides
`timescale 1ns/1ps
module chp_monitor (
   input wire logic core_clk,
   input wire logic rst,
   input wire chp_pkg::chp_mode_type port_mode,
   input wire logic [2:0] addr,
   input wire logic card_enable_n,
   input wire logic task_file_select_n,
   input wire logic control_block_select_n,
   input wire logic io_read_strobe_n,
   input wire logic io_write_strobe_n,
   input wire logic dma_acknowledge_n,
   input wire logic [15:0] dev_d,
   input wire logic dev_d_oe,
   input wire logic input_acknowledge_n,
   input wire logic dma_request
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // ==========================================================
   // Sequences
   sequence dma_read_start_s;
      !dma_acknowledge_n && $fell(io_read_strobe_n);
   endsequence
   sequence read_pulse_s;
      io_read_strobe_n == 1'b0 [*3] ##1 io_read_strobe_n;
   endsequence
   sequence io_read_s;
      (port_mode == chp_pkg::CHP_MODE_IO && !card_enable_n && !io_read_strobe_n) [*2];
   endsequence

   // ==========================================================
   // Checks
   req_hold_a: assert property (dma_request && dma_acknowledge_n && task_file_select_n
      && control_block_select_n |=> dma_request) else $error("request dropped before ack");
   req_drop_a: assert property (!dma_acknowledge_n && ($rose(io_read_strobe_n)
      || $rose(io_write_strobe_n)) |=> !dma_request) else $error("request kept after word");
   strobe_width_a: assert property (dma_read_start_s |-> read_pulse_s)
      else $error("dma strobe width wrong");
   one_dir_a: assert property (!dma_acknowledge_n |-> io_read_strobe_n || io_write_strobe_n)
      else $error("both strobes during dma");
   sel_quiet_a: assert property (!dma_acknowledge_n |-> task_file_select_n
      && control_block_select_n) else $error("select during dma ack");
   ack_mem_a: assert property (port_mode == chp_pkg::CHP_MODE_MEMORY |-> input_acknowledge_n)
      else $error("input ack in memory mode");
   ack_io_a: assert property (io_read_s |-> ##[0:1] !input_acknowledge_n)
      else $error("no input ack on io read");
   ack_cause_a: assert property (!input_acknowledge_n |-> port_mode == chp_pkg::CHP_MODE_IO)
      else $error("input ack outside io mode");
   req_mode_a: assert property (port_mode != chp_pkg::CHP_MODE_DISK |-> !dma_request)
      else $error("request outside disk mode");
   byte_reg_a: assert property (port_mode == chp_pkg::CHP_MODE_DISK && dev_d_oe
      && dma_acknowledge_n && addr != chp_pkg::TF_DATA |-> dev_d[15:8] == 8'h00)
      else $error("register read on high byte");
endmodule

// >>> chp_pkg.sv
// Purpose: Shared constants, types and buffer step for the card host port
// Assumes: One 10 MHz clock, synchronous active-high reset
// Notes: Pin levels are active low where named with _n
package chp_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int STROBE_NS = 300;
   localparam int RECOVER_NS = 200;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
   localparam logic [3:0] RECOVER_LAST = 4'(RECOVER_CYC - 1);

   // ==========================================================
   // Register map and fields
   localparam logic [2:0] TF_DATA = 3'h0;
   localparam logic [2:0] TF_DRIVE = 3'h6;
   localparam logic [2:0] TF_COMMAND = 3'h7;
   localparam int DRIVE_DEV_BIT = 4;
   localparam int DATA_W = 16;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
   localparam logic [15:0] FLOAT_WORD = 16'hFFFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // ==========================================================
   // Enumerations
   typedef enum logic [2:0] {
      CHP_MODE_MEMORY = 3'b001,
      CHP_MODE_IO = 3'b010,
      CHP_MODE_DISK = 3'b100
   } chp_mode_type;

   typedef enum logic [3:0] {
      CHP_H_IDLE = 4'b0001,
      CHP_H_SETUP = 4'b0010,
      CHP_H_STROBE = 4'b0100,
      CHP_H_RECOVER = 4'b1000
   } chp_host_state_type;

   // ==========================================================
   // Two-entry buffer; entry 0 is the head
   typedef struct packed {
      logic [1:0][DATA_W-1:0] mem;
      logic [1:0] cnt;
   } chp_fifo_type;

   function automatic chp_fifo_type chp_fifo_step(chp_fifo_type f, logic push, logic pop,
                                                  logic [DATA_W-1:0] din);
      chp_fifo_type r;
      r = f;
      if (pop && f.cnt != 2'h0) begin
         r.mem[0] = f.mem[1];
         r.cnt = f.cnt - 2'h1;
      end
      if (push && r.cnt < BUF_DEPTH) begin
         r.mem[r.cnt[0]] = din;
         r.cnt = r.cnt + 2'h1;
      end
      return r;
   endfunction
endpackage
